// ### p5pm_monitor.sv
// pad checker for the port 5 mode block; rdata is connected but not checked
`timescale 1ns/1ps
module p5pm_monitor (
  input wire logic                clock,
  input wire logic                rst_n,
  input wire p5pm_pkg::p5pm_req_s req,
  input wire logic [7:0]          rdata,
  input wire logic [3:0]          port_data_out,
  input wire logic [7:0]          upper_pullup_block,
  input wire p5pm_pkg::p5pm_pad_s pad
);
  import p5pm_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_od_low_data: assert property (pad.pad_oe[0] && !pad.pad_out[0] |->
    !$past(port_data_out[0])) else $error("low drive without zero data");
  a_pp_high_drive: assert property (pad.pad_out[1] |->
    pad.pad_oe[1] && $past(port_data_out[1])) else $error("high out without drive");
  a_pp_mode_oe: assert property (req.wr && req.addr == P5PM_MODE_ADDR &&
    req.wdata[5:4] == 2'h2 |=> ##1 pad.pad_oe[2]) else $error("push-pull not driven");
  a_seg_quiet: assert property (pad.lcd_segment_output[3] |->
    !pad.pad_oe[3] && !pad.pullup_on[3]) else $error("segment pin not released");
  a_seg_select: assert property (req.wr && req.addr == P5PM_MODE_ADDR &&
    req.wdata[7:6] == 2'h3 |=> ##1 pad.lcd_segment_output[3]) else $error("no segment");
  a_pullup_map: assert property (req.wr && req.addr == P5PM_PULLUP_ADDR |=> ##1
    pad.pullup_on[7:4] == ($past(req.wdata[7:4], 2) & ~$past(upper_pullup_block[7:4])))
    else $error("upper pull-up mismatch");
  a_upper_block: assert property (pad.pullup_on[5] |->
    !$past(upper_pullup_block[5])) else $error("pull-up on while blocked");
  a_input_idle: assert property (req.wr && req.addr == P5PM_MODE_ADDR &&
    req.wdata[1:0] == 2'h0 |=> ##1 !pad.pad_oe[0]) else $error("input pin driven");
  cover property (pad.lcd_segment_output[3]);
  cover property (pad.pad_oe[2] && pad.pad_out[2]);
  cover property (pad.pullup_on[4]);
endmodule
bind p5pm_port5_pin_mode_pullup p5pm_monitor i_p5pm_monitor (.clock, .rst_n, .req, .rdata,
  .port_data_out, .upper_pullup_block, .pad);

// ### p5pm_pkg.sv
// shared constants, mode codes and pad bundle for the port 5 low-pin mode block
// Functional notes
// - mode code 01: open-drain, pull low for data 0, release for data 1
// - mode code 10: push-pull, pin driven high and low following the data bit
// - pull-up enable bit 1 connects the pin's pull-up, 0 disconnects it
// - pull-up enable bit n controls pin n, upper bits map to pins 4 to 7
// - pull-up forced off in push-pull or segment mode, whatever the enable bit says
package p5pm_pkg;

  localparam int unsigned P5PM_DATA_W   = 8;
  localparam int unsigned P5PM_ADDR_W   = 8;
  localparam int unsigned P5PM_PINS     = 8;
  localparam int unsigned P5PM_LOW_PINS = 4;
  localparam int unsigned P5PM_FIELD_W  = 2;

  localparam logic [P5PM_ADDR_W-1:0] P5PM_PULLUP_ADDR = 8'hef;
  localparam logic [P5PM_ADDR_W-1:0] P5PM_MODE_ADDR   = 8'hfa;

  localparam logic [P5PM_DATA_W-1:0] P5PM_PULLUP_RST = 8'h00;
  localparam logic [P5PM_DATA_W-1:0] P5PM_MODE_RST   = 8'h00;
  localparam logic [P5PM_DATA_W-1:0] P5PM_UNMAPPED   = 8'h00;

  typedef enum logic [P5PM_FIELD_W-1:0] {
    P5PM_MODE_INPUT     = 2'h0,
    P5PM_MODE_OPENDRAIN = 2'h1,
    P5PM_MODE_PUSHPULL  = 2'h2,
    P5PM_MODE_SEGMENT   = 2'h3
  } p5pm_mode_e;

  // register-addressing access from the core
  typedef struct packed {
    logic                   wr;
    logic                   rd;
    logic [P5PM_ADDR_W-1:0] addr;
    logic [P5PM_DATA_W-1:0] wdata;
  } p5pm_req_s;

  // per-port pad controls, one bit per low pin for drive and segment, one bit per pin for pull-up
  typedef struct packed {
    logic [P5PM_LOW_PINS-1:0] pad_out;
    logic [P5PM_LOW_PINS-1:0] pad_oe;
    logic [P5PM_LOW_PINS-1:0] lcd_segment_output;
    logic [P5PM_PINS-1:0]     pullup_on;
  } p5pm_pad_s;

endpackage

// ### p5pm_port5_pin_mode_pullup.sv
// port 5 low-pin mode decode, pull-up enable register and pad control outputs
`timescale 1ns/1ps
module p5pm_port5_pin_mode_pullup #(
  parameter int unsigned DATA_W   = 8,
  parameter int unsigned LOW_PINS = 4
) (
  input  wire  logic                                 clock,
  input  wire  logic                                 rst_n,
  input  wire  p5pm_pkg::p5pm_req_s                  req,
  output logic [p5pm_pkg::P5PM_DATA_W-1:0]           rdata,
  input  wire  logic [p5pm_pkg::P5PM_LOW_PINS-1:0]   port_data_out,
  input  wire  logic [p5pm_pkg::P5PM_PINS-1:0]       upper_pullup_block,
  output p5pm_pkg::p5pm_pad_s                        pad
);
  import p5pm_pkg::*;

  // the fixed layout serves one 8-bit register carrying four two-bit mode fields
  if (DATA_W != P5PM_DATA_W || LOW_PINS != P5PM_LOW_PINS)
  begin : g_check
    $error("p5pm: only an 8-bit register and four low pins are supported");
  end

  if (P5PM_LOW_PINS * P5PM_FIELD_W != P5PM_DATA_W)
  begin : g_check_fields
    $error("p5pm: the mode fields must fill the control register exactly");
  end

  if (P5PM_PINS > P5PM_DATA_W || P5PM_LOW_PINS > P5PM_PINS)
  begin : g_check_pins
    $error("p5pm: every pin needs its own pull-up enable bit");
  end

  if (P5PM_PULLUP_ADDR == P5PM_MODE_ADDR)
  begin : g_check_addr
    $error("p5pm: the two registers need distinct addresses");
  end

  logic [P5PM_DATA_W-1:0]   pullup_reg;
  logic [P5PM_DATA_W-1:0]   pullup_next;
  logic [P5PM_DATA_W-1:0]   mode_reg;
  logic [P5PM_DATA_W-1:0]   mode_next;
  logic [P5PM_DATA_W-1:0]   rdata_reg;
  logic [P5PM_DATA_W-1:0]   rdata_next;
  p5pm_pad_s                pad_reg;
  p5pm_pad_s                pad_next;
  logic                     wr_pullup;
  logic                     wr_mode;
  logic                     rd_pullup;
  logic                     rd_mode;
  logic                     rd_other;
  logic [P5PM_LOW_PINS-1:0] pin_out;
  logic [P5PM_LOW_PINS-1:0] pin_oe;
  logic [P5PM_LOW_PINS-1:0] pin_seg;
  logic [P5PM_PINS-1:0]     pin_block;
  logic [P5PM_PINS-1:0]     pin_pullup;

  // register-address decode; writes elsewhere are dropped, reads elsewhere return zero
  always_comb
  begin
    wr_pullup = 1'b0;
    wr_mode   = 1'b0;
    rd_pullup = 1'b0;
    rd_mode   = 1'b0;
    rd_other  = 1'b0;
    case (req.addr)
      P5PM_PULLUP_ADDR:
      begin
        wr_pullup = req.wr;
        rd_pullup = req.rd;
      end
      P5PM_MODE_ADDR:
      begin
        wr_mode = req.wr;
        rd_mode = req.rd;
      end
      default:
      begin
        rd_other = req.rd;
      end
    endcase
  end

  // control registers; reset leaves every pin an input with its pull-up off
  always_comb
  begin
    pullup_next = pullup_reg;
    mode_next   = mode_reg;
    if (wr_pullup)
    begin
      pullup_next = req.wdata;
    end
    if (wr_mode)
    begin
      mode_next = req.wdata;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pullup_reg <= P5PM_PULLUP_RST;
      mode_reg   <= P5PM_MODE_RST;
    end
    else
    begin
      pullup_reg <= pullup_next;
      mode_reg   <= mode_next;
    end
  end

  // read data holds until the next read; a read beside a write returns the old value
  always_comb
  begin
    rdata_next = rdata_reg;
    if (rd_other)
    begin
      rdata_next = P5PM_UNMAPPED;
    end
    if (rd_pullup)
    begin
      rdata_next = pullup_reg;
    end
    if (rd_mode)
    begin
      rdata_next = mode_reg;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rdata_reg <= P5PM_UNMAPPED;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  // per-pin mode decode; pins 4 to 7 take their block term from the upper control logic
  genvar gi;
  for (gi = 0; gi < P5PM_PINS; gi++)
  begin : g_pin
    if (gi < P5PM_LOW_PINS)
    begin : g_low
      p5pm_mode_e mode;
      logic       out_bit;
      logic       oe_bit;
      logic       seg_bit;
      logic       block_bit;
      assign mode = p5pm_mode_e'(mode_reg[gi*P5PM_FIELD_W +: P5PM_FIELD_W]);
      always_comb
      begin
        out_bit   = 1'b0;
        oe_bit    = 1'b0;
        seg_bit   = 1'b0;
        block_bit = 1'b0;
        case (mode)
          P5PM_MODE_INPUT:
          begin
            oe_bit = 1'b0;
          end
          P5PM_MODE_OPENDRAIN:
          begin
            out_bit = 1'b0;
            oe_bit  = ~port_data_out[gi];
          end
          P5PM_MODE_PUSHPULL:
          begin
            out_bit   = port_data_out[gi];
            oe_bit    = 1'b1;
            block_bit = 1'b1;
          end
          P5PM_MODE_SEGMENT:
          begin
            seg_bit   = 1'b1;
            block_bit = 1'b1;
          end
          default:
          begin
            oe_bit = 1'b0;
          end
        endcase
      end
      assign pin_out[gi]   = out_bit;
      assign pin_oe[gi]    = oe_bit;
      assign pin_seg[gi]   = seg_bit;
      assign pin_block[gi] = block_bit;
    end
    else
    begin : g_high
      assign pin_block[gi] = upper_pullup_block[gi];
    end
    assign pin_pullup[gi] = pullup_reg[gi] & ~pin_block[gi];
  end

  // pad controls are registered so the pads never see decode glitches
  always_comb
  begin
    pad_next.pad_out            = pin_out;
    pad_next.pad_oe             = pin_oe;
    pad_next.lcd_segment_output = pin_seg;
    pad_next.pullup_on          = pin_pullup;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pad_reg <= '0;
    end
    else
    begin
      pad_reg <= pad_next;
    end
  end

  assign pad   = pad_reg;
  assign rdata = rdata_reg;

endmodule

// ### tb_port5_pin_mode_pullup.sv
// self-checking bench for the port 5 mode block
`timescale 1ns/1ps
module tb_port5_pin_mode_pullup;
  import p5pm_pkg::*;
  logic       clock = 0, rst_n = 0, rd_q = 0, pad_due = 0, pad_q = 0;
  p5pm_req_s  req = '0;
  logic [7:0] rdata, m, p, b = '0;
  logic [3:0] d = '0;
  logic [1:0] f;
  p5pm_pad_s  pad, ep;
  int         failures = 0, n_tests = 0, cyc = 0;
  logic [7:0] q[$];
  p5pm_pad_s  pq[$];
  p5pm_port5_pin_mode_pullup i_p5pm_port5_pin_mode_pullup (.clock, .rst_n, .req, .rdata,
    .port_data_out(d), .upper_pullup_block(b), .pad);
  initial forever #2.5 clock = ~clock;
  task automatic close_out;
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk_rdata(input logic [7:0] x, y);
    n_tests++;
    if (x !== y)
    begin
      failures++;
      $display("[FAIL] rdata exp %h got %h", x, y);
    end
  endtask
  task automatic chk_pad(input p5pm_pad_s x, y);
    n_tests++;
    if (x !== y)
    begin
      failures++;
      $display("[FAIL] pad exp %h got %h", x, y);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, v);
    @(negedge clock);
    req = '{wr: w, rd: !w, addr: a, wdata: v};
    pad_due = 1'b0;
  endtask
  task automatic after_reset;
    pq.push_back('0);
    pad_due = 1'b1;
    q.push_back(P5PM_MODE_RST);
    acc(0, P5PM_MODE_ADDR, 8'h00);
    q.push_back(P5PM_PULLUP_RST);
    acc(0, P5PM_PULLUP_ADDR, 8'h00);
  endtask
  always @(posedge clock)
  begin
    rd_q <= req.rd && rst_n;
    pad_q <= pad_due;
    cyc++;
    if (cyc > 2000)
    begin
      failures++;
      close_out;
    end
  end
  always @(negedge clock)
    if (rd_q) chk_rdata(q.pop_front(), rdata);
  always @(negedge clock)
    if (pad_q) chk_pad(pq.pop_front(), pad);
  initial
  begin
    void'($urandom(32'he909b11f));
    repeat (5) @(negedge clock);
    rst_n = 1;
    after_reset;
    repeat (30)
    begin
      m = 8'($urandom);
      p = 8'($urandom);
      acc(1, P5PM_MODE_ADDR, m);
      acc(1, P5PM_PULLUP_ADDR, p);
      @(negedge clock);
      req = '0;
      d = 4'($urandom);
      b = 8'($urandom);
      for (int i = 0; i < 4; i++)
      begin
        f = m[2*i+:2];
        ep.pad_out[i] = f == 2'h2 && d[i];
        ep.pad_oe[i] = f == 2'h2 || (f == 2'h1 && !d[i]);
        ep.lcd_segment_output[i] = f == 2'h3;
        ep.pullup_on[i] = p[i] && !f[1];
      end
      ep.pullup_on[7:4] = p[7:4] & ~b[7:4];
      pq.push_back(ep);
      pad_due = 1'b1;
      q.push_back(m);
      acc(0, P5PM_MODE_ADDR, 8'h00);
      q.push_back(p);
      acc(0, P5PM_PULLUP_ADDR, 8'h00);
      q.push_back(P5PM_UNMAPPED);
      acc(0, 8'h5a, 8'h00);
    end
    @(negedge clock);
    req = '0;
    rst_n = 0;
    repeat (2) @(negedge clock);
    rst_n = 1;
    after_reset;
    @(negedge clock);
    req = '0;
    @(negedge clock);
    close_out;
  end
endmodule
